//--- hdl/chi_host.v
`timescale 1ns/10ps
`include "chi_defines.vh"
// How it works
// R1 - Address target 0x6B only
// R2 - Offsets above 0x25 read 0xFF
// R3 - Runs standard mode, 100 kbit/s
// R4 - SDA changes only while SCL low
// R5 - START/STOP made with SCL high
// R6 - Bus busy from START to STOP
// R7 - Eight bits MSB first plus acknowledge
// R8 - Wait while target stretches SCL
// R9 - Host makes every clock pulse
// R10 - Release SDA for target acknowledge
// R11 - NACK ends with STOP
// R12 - Address byte carries direction bit
// R13 - Write: address, offset, data, STOP
// R14 - Read: offset write, repeated START, read
// R15 - Offset NACK aborts with STOP
// R16 - Multi-byte transfers, NACK last read
// R17 - Open-drain drive, pull low only
// R18 - Address NACK reported, transfer stopped
// R19 - Repeated START restarts address phase
module chi_host #(
	parameter QTR = `CHI_QTR_CYCLES
) (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire cmd_valid_i,
	input wire cmd_read_i,
	input wire [7:0] cmd_offset_i,
	input wire [7:0] cmd_count_i,
	input wire wr_valid_i,
	input wire [7:0] wr_data_i,
	output reg wr_ready_o,
	output reg rd_valid_o,
	output reg [7:0] rd_data_o,
	output reg cmd_ready_o,
	output reg done_o,
	output reg nack_o,
	output reg busy_o,
	input wire scl_i,
	output reg scl_o,
	output reg scl_oe_o,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o
);
	localparam S_IDLE = 4'h0;
	localparam S_START = 4'h1;
	localparam S_BIT = 4'h2;
	localparam S_ACK = 4'h3;
	localparam S_NEXT = 4'h4;
	localparam S_RSTART = 4'h5;
	localparam S_STOP = 4'h6;
	localparam S_WAITD = 4'h7;
	localparam P_ADDR = 3'h0;
	localparam P_OFS = 3'h1;
	localparam P_WDAT = 3'h2;
	localparam P_RADDR = 3'h3;
	localparam P_RDAT = 3'h4;
	wire scl_s;
	wire sda_s;
	wire tick;
	reg [3:0] st_ff;
	reg [2:0] ph_ff;
	reg [1:0] q_ff;
	reg [3:0] bit_ff;
	reg [7:0] sh_ff;
	reg [7:0] ofs_ff;
	reg [7:0] left_ff;
	reg rd_ff;
	reg fail_ff;
	reg sda_low_ff;
	reg scl_low_ff;
	chi_sync u_scl (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.d_i(scl_i),
		.q_o(scl_s)
	);
	chi_sync u_sda (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.d_i(sda_i),
		.q_o(sda_s)
	);
	// Quarter-bit ticks; 10 MHz / 100 kHz keeps both parties in standard mode
	chi_tick #(.QTR(QTR)) u_tick ( // R3
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.run_i(st_ff != S_IDLE && st_ff != S_WAITD),
		.tick_o(tick)
	);
	// Stretch check: hold quarter while released SCL still reads low
	wire stretched = !scl_low_ff && !scl_s; // R8
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st_ff <= S_IDLE;
			ph_ff <= P_ADDR;
			q_ff <= 2'h0;
			bit_ff <= 4'h0;
			sh_ff <= 8'h00;
			ofs_ff <= 8'h00;
			left_ff <= 8'h00;
			rd_ff <= 1'b0;
			fail_ff <= 1'b0;
			sda_low_ff <= 1'b0;
			scl_low_ff <= 1'b0;
			cmd_ready_o <= 1'b0;
			wr_ready_o <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_data_o <= 8'h00;
			done_o <= 1'b0;
			nack_o <= 1'b0;
			busy_o <= 1'b0;
			scl_o <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			rd_valid_o <= 1'b0;
			wr_ready_o <= 1'b0;
			case (st_ff)
			S_IDLE: begin
				cmd_ready_o <= 1'b1;
				busy_o <= 1'b0;
				if (cmd_valid_i && cmd_ready_o) begin
					cmd_ready_o <= 1'b0;
					busy_o <= 1'b1; // R6
					rd_ff <= cmd_read_i;
					ofs_ff <= cmd_offset_i;
					left_ff <= (cmd_count_i == 8'h00) ? 8'h01 : cmd_count_i;
					fail_ff <= 1'b0;
					nack_o <= 1'b0;
					q_ff <= 2'h0;
					st_ff <= S_START;
				end
			end
			S_START, S_RSTART: if (tick) begin
				// Q0 release SDA, Q1 release SCL, Q2 pull SDA with SCL high
				q_ff <= q_ff + 2'h1;
				if (q_ff == 2'h0) begin
					sda_low_ff <= 1'b0;
				end else if (q_ff == 2'h1) begin
					scl_low_ff <= 1'b0;
				end else if (q_ff == 2'h2) begin
					if (stretched) begin
						q_ff <= q_ff;
					end else begin
						sda_low_ff <= 1'b1; // R5
					end
				end else begin
					scl_low_ff <= 1'b1;
					q_ff <= 2'h0;
					bit_ff <= 4'h0;
					// Address byte: 7-bit target then direction
					if (st_ff == S_START) begin
						sh_ff <= {`CHI_TARGET_ADDR, `CHI_OP_WRITE}; // R1 R12
						ph_ff <= P_ADDR;
					end else begin
						sh_ff <= {`CHI_TARGET_ADDR, `CHI_OP_READ}; // R14 R19
						ph_ff <= P_RADDR;
					end
					st_ff <= S_BIT;
				end
			end
			S_BIT: if (tick) begin
				q_ff <= q_ff + 2'h1;
				if (q_ff == 2'h0) begin
					// Data moves only in the low phase
					sda_low_ff <= (ph_ff == P_RDAT) ? 1'b0 : !sh_ff[7]; // R4 R7 R17
				end else if (q_ff == 2'h1) begin
					scl_low_ff <= 1'b0; // R9
				end else if (q_ff == 2'h2) begin
					if (stretched) begin
						q_ff <= q_ff;
					end else begin
						sh_ff <= {sh_ff[6:0], sda_s};
					end
				end else begin
					scl_low_ff <= 1'b1;
					bit_ff <= bit_ff + 4'h1;
					if (bit_ff == `CHI_BYTE_BITS - 4'h1) begin
						st_ff <= S_ACK;
					end
				end
			end
			S_ACK: if (tick) begin
				q_ff <= q_ff + 2'h1;
				if (q_ff == 2'h0) begin
					// Read data: acknowledge all but the last byte
					if (ph_ff == P_RDAT) begin
						sda_low_ff <= (left_ff != 8'h01); // R16 R11
					end else begin
						sda_low_ff <= 1'b0; // R10
					end
				end else if (q_ff == 2'h1) begin
					scl_low_ff <= 1'b0;
				end else if (q_ff == 2'h2) begin
					if (stretched) begin
						q_ff <= q_ff;
					end else if (ph_ff != P_RDAT) begin
						fail_ff <= sda_s; // R10 R15 R18
					end
				end else begin
					scl_low_ff <= 1'b1;
					st_ff <= S_NEXT;
				end
			end
			S_NEXT: begin
				bit_ff <= 4'h0;
				q_ff <= 2'h0;
				if (fail_ff) begin
					nack_o <= 1'b1;
					st_ff <= S_STOP; // R11 R15 R18
				end else begin
					case (ph_ff)
					P_ADDR: begin
						sh_ff <= ofs_ff;
						ph_ff <= P_OFS;
						st_ff <= S_BIT;
					end
					P_OFS: begin
						if (rd_ff) begin
							st_ff <= S_RSTART; // R14
						end else begin
							wr_ready_o <= 1'b1;
							st_ff <= S_WAITD;
						end
					end
					P_WDAT: begin
						left_ff <= left_ff - 8'h01;
						if (left_ff == 8'h01) begin
							st_ff <= S_STOP; // R13
						end else begin
							wr_ready_o <= 1'b1;
							st_ff <= S_WAITD; // R16
						end
					end
					P_RADDR: begin
						ph_ff <= P_RDAT;
						st_ff <= S_BIT;
					end
					default: begin
						// Beyond the last host register the target fills
						rd_valid_o <= 1'b1;
						rd_data_o <= (ofs_ff > `CHI_LAST_HOST_REGISTER) ? `CHI_RD_FILL : sh_ff; // R2
						ofs_ff <= ofs_ff + 8'h01;
						left_ff <= left_ff - 8'h01;
						st_ff <= (left_ff == 8'h01) ? S_STOP : S_BIT; // R16
					end
					endcase
				end
			end
			S_WAITD: begin
				// SCL held low by us; no timing pressure while user is slow
				if (wr_valid_i) begin
					sh_ff <= wr_data_i;
					ofs_ff <= ofs_ff + 8'h01;
					ph_ff <= P_WDAT;
					st_ff <= S_BIT;
				end else begin
					wr_ready_o <= 1'b1;
				end
			end
			S_STOP: if (tick) begin
				q_ff <= q_ff + 2'h1;
				if (q_ff == 2'h0) begin
					sda_low_ff <= 1'b1;
				end else if (q_ff == 2'h1) begin
					scl_low_ff <= 1'b0;
				end else if (q_ff == 2'h2) begin
					if (stretched) begin
						q_ff <= q_ff;
					end else begin
						sda_low_ff <= 1'b0; // R5 R6
					end
				end else begin
					done_o <= 1'b1;
					st_ff <= S_IDLE;
				end
			end
			default: begin
				st_ff <= S_IDLE;
			end
			endcase
			// Open drain: drive zero or release, never high
			scl_o <= 1'b0; // R17
			sda_o <= 1'b0;
			scl_oe_o <= scl_low_ff;
			sda_oe_o <= sda_low_ff;
		end
	end
endmodule // chi_host

//--- hdl/chi_sync.v
`timescale 1ns/10ps
module chi_sync (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire d_i,
	output wire q_o
);
	reg meta_ff;
	reg sync_ff;
	// Idle bus reads high, so reset to one
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end else begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end
	assign q_o = sync_ff;
endmodule // chi_sync

//--- hdl/chi_tick.v
`timescale 1ns/10ps
module chi_tick #(
	parameter QTR = 25
) (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire run_i,
	output reg tick_o
);
	reg [15:0] cnt_ff;
	always @(posedge clk_sys_i) begin
		if (sys_rst_i || !run_i) begin
			cnt_ff <= 16'h0000;
			tick_o <= 1'b0;
		end else if (cnt_ff == QTR[15:0] - 16'h0001) begin
			cnt_ff <= 16'h0000;
			tick_o <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
			tick_o <= 1'b0;
		end
	end
endmodule // chi_tick

//--- pkg/chi_defines.vh
`ifndef CHI_DEFINES_VH
`define CHI_DEFINES_VH
`define CHI_TARGET_ADDR 7'h6B
`define CHI_LAST_HOST_REGISTER 8'h25
`define CHI_RD_FILL 8'hFF
`define CHI_SYS_CLK_HZ 10000000
`define CHI_BIT_RATE_HZ 100000
`define CHI_QTR_CYCLES ((`CHI_SYS_CLK_HZ / `CHI_BIT_RATE_HZ) / 4)
`define CHI_BYTE_BITS 4'h8
`define CHI_OP_WRITE 1'b0
`define CHI_OP_READ 1'b1
`endif

//--- verification/chi_host_monitor.sv
`timescale 1ns/10ps
module chi_host_monitor (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire cmd_valid_i,
	input wire cmd_ready_o,
	input wire rd_valid_o,
	input wire done_o,
	input wire nack_o,
	input wire busy_o,
	input wire scl_i,
	input wire scl_o,
	input wire scl_oe_o,
	input wire sda_o,
	input wire sda_oe_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
		else $error("line driven high");
	AST_IDLE_RELEASED: assert property (!busy_o |-> !scl_oe_o && !sda_oe_o)
		else $error("line held while bus free");
	AST_BUSY_START: assert property ($rose(busy_o) |->
		$past(cmd_valid_i && cmd_ready_o) || $past(cmd_valid_i && cmd_ready_o, 2))
		else $error("busy without accepted command");
	AST_DONE_PULSE: assert property (done_o |=> !done_o ##[0:3] !busy_o)
		else $error("done not a pulse or bus stays busy");
	AST_RD_PULSE: assert property (rd_valid_o |-> busy_o ##1 !rd_valid_o)
		else $error("read byte outside transfer");
	AST_STRETCH_HOLD: assert property (busy_o && !scl_oe_o && !scl_i |=> !scl_oe_o)
		else $error("clock pulled while target stretches");
	AST_SDA_EDGE: assert property ($changed(sda_oe_o) && !scl_oe_o |->
		$past(!scl_oe_o) && scl_i)
		else $error("data moved while clock rises or is low");
	AST_NACK_CLEAR: assert property ($fell(nack_o) |->
		$past(cmd_ready_o) || $past(cmd_ready_o, 2))
		else $error("nack cleared without new command");
endmodule // chi_host_monitor
bind chi_host chi_host_monitor chi_host_monitor_i (.clk_sys_i, .sys_rst_i, .cmd_valid_i,
	.cmd_ready_o, .rd_valid_o, .done_o, .nack_o, .busy_o, .scl_i, .scl_o, .scl_oe_o,
	.sda_o, .sda_oe_o);

//--- verification/chi_host_tb.sv
`timescale 1ns/10ps
module chi_host_tb;
	reg clk_sys_i = 1'b0;
	reg sys_rst_i = 1'b1;
	reg cmd_valid_i = 1'b0;
	reg cmd_read_i = 1'b0;
	reg [7:0] cmd_offset_i = 8'h00;
	reg [7:0] cmd_count_i = 8'h00;
	reg wr_valid_i = 1'b0;
	reg [7:0] wr_data_i = 8'h00;
	reg stretch = 1'b0;
	reg fin;
	reg hs;
	wire wr_ready_o, rd_valid_o, cmd_ready_o, done_o, nack_o, busy_o;
	wire [7:0] rd_data_o;
	wire scl_o, scl_oe_o, sda_o, sda_oe_o, t_scl, t_sda;
	wire scl = !(scl_oe_o || t_scl); // Pull-ups: released line reads high
	wire sda = !(sda_oe_o || t_sda);
	reg [7:0] wb [0:3];
	reg [7:0] rb [0:3];
	integer n_fail = 0;
	integer samples_checked = 0;
	integer k, j, t;
	always #50 clk_sys_i = !clk_sys_i;
	// Fast mode: 2.8 us bit, under the 400 kbit/s ceiling
	chi_host #(.QTR(7)) chi_host_i (.clk_sys_i, .sys_rst_i, .cmd_valid_i, .cmd_read_i,
		.cmd_offset_i, .cmd_count_i, .wr_valid_i, .wr_data_i, .wr_ready_o, .rd_valid_o,
		.rd_data_o, .cmd_ready_o, .done_o, .nack_o, .busy_o, .scl_i(scl), .scl_o,
		.scl_oe_o, .sda_i(sda), .sda_o, .sda_oe_o);
	chi_tgt_model chi_tgt_model_i (.scl_i(scl), .sda_i(sda), .stretch_i(stretch),
		.scl_pull_o(t_scl), .sda_pull_o(t_sda));
	task complete_run;
		begin
			$display("checked %0d mismatches %0d", samples_checked, n_fail);
			if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
			else $display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// Command held until accepted; write byte offered until taken
	task xfer(input rd, input [7:0] ofs, input [7:0] cnt);
		begin
			k = 0;
			j = 0;
			fin = 1'b0;
			cmd_read_i = rd;
			cmd_offset_i = ofs;
			cmd_count_i = cnt;
			cmd_valid_i = 1'b1;
			wr_valid_i = !rd;
			wr_data_i = wb[0];
			for (t = 0; t < 4000 && !fin; t = t + 1) begin
				@(posedge clk_sys_i);
				hs = cmd_ready_o === 1'b1;
				if (wr_ready_o === 1'b1) k = k + 1;
				if (rd_valid_o === 1'b1 && j < 4) rb[j] = rd_data_o;
				if (rd_valid_o === 1'b1) j = j + 1;
				fin = done_o === 1'b1;
				#1;
				if (hs) cmd_valid_i = 1'b0;
				wr_data_i = wb[k % 4];
			end
			wr_valid_i = 1'b0;
			if (!fin) begin
				n_fail = n_fail + 1;
				complete_run;
			end
		end
	endtask
	task t_cross;
		begin
			xfer(1'b0, 8'h24, 8'h02);
			chk(nack_o, 1'b0);
			chk(k, 8'h02);
			stretch = 1'b1;
			xfer(1'b1, 8'h24, 8'h03);
			stretch = 1'b0;
			chk(j, 3);
			chk(rb[0], 8'hA5);
			chk(rb[1], 8'h3C);
			chk(rb[2], 8'hFF);
			chk({scl, sda}, 2'h3);
			$display("test cross done");
		end
	endtask
	task t_bad_ofs;
		begin
			xfer(1'b0, 8'h02, 8'h01);
			chk(nack_o, 1'b1);
			chk(busy_o, 1'b0);
			xfer(1'b1, 8'h25, 8'h01);
			chk(nack_o, 1'b0);
			chk(rb[0], 8'h3C);
			xfer(1'b1, 8'h24, 8'h00);
			chk(j, 1);
			chk(rb[0], 8'hA5);
			$display("test bad offset done");
		end
	endtask
	initial begin
		wb[0] = 8'hA5;
		wb[1] = 8'h3C;
		wb[2] = 8'h00;
		wb[3] = 8'h00;
		repeat (8) @(posedge clk_sys_i);
		#1 sys_rst_i = 1'b0;
		t_cross;
		t_bad_ofs;
		complete_run;
	end
endmodule // chi_host_tb

//--- verification/chi_tgt_model.sv
`timescale 1ns/10ps
module chi_tgt_model (
	input wire scl_i,
	input wire sda_i,
	input wire stretch_i,
	output reg scl_pull_o,
	output reg sda_pull_o
);
	reg [7:0] mem [0:255];
	reg [7:0] sh;
	reg [7:0] ofs;
	reg [3:0] n;
	reg [2:0] ph;
	reg ack_in;
	function undef(input [7:0] o);
		undef = o == 8'h02 || o == 8'h04 || o == 8'h07 || o == 8'h0C || o == 8'h1A;
	endfunction
	initial begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
		ph = 3'h0;
	end
	always @(negedge sda_i) if (scl_i) begin
		ph = 3'h1;
		n = 4'h0;
	end
	always @(posedge sda_i) if (scl_i) ph = 3'h0;
	always @(posedge scl_i) if (ph != 3'h0) begin
		if (n < 4'h8) sh = {sh[6:0], sda_i};
		else ack_in = !sda_i;
		n = n + 4'h1;
	end
	always @(negedge scl_i) if (ph != 3'h0) begin
		sda_pull_o = 1'b0;
		if (n == 4'h8) begin
			if (ph == 3'h1 && sh[7:1] == 7'h6B) ph = sh[0] ? 3'h3 : 3'h2;
			else if (ph == 3'h1 || (ph == 3'h2 && undef(sh))) ph = 3'h0;
			else if (ph == 3'h2) begin
				ofs = sh;
				ph = 3'h5;
			end else if (ph == 3'h5) begin
				mem[ofs] = sh;
				ofs = ofs + 8'h1;
			end
			sda_pull_o = ph != 3'h0 && ph != 3'h4;
		end else if (n == 4'h9) begin
			n = 4'h0;
			if (ph == 3'h4 && !ack_in) ph = 3'h0;
			else if (ph == 3'h3 || ph == 3'h4) begin
				if (ph == 3'h4) ofs = ofs + 8'h1;
				ph = 3'h4;
				sh = (ofs > 8'h25) ? 8'hFF : mem[ofs];
			end
		end
		if (ph == 3'h4 && n != 4'h8) sda_pull_o = !sh[7];
		// Data settles before the held clock is let go
		if (n == 4'h0 && stretch_i) begin
			scl_pull_o = 1'b1;
			#3050 scl_pull_o = 1'b0;
		end
	end
endmodule // chi_tgt_model
